// [aic_ctrl.sv]
// Purpose: Register-controlled front end of a 10-bit successive approximation
//          converter: input setup, supply switches, channel, start logic.
// Assumes: Register port strobes are single cycles; comparator input is
//          synchronous and high when the input is at or above the trial code.
// Notes:   Read data stands in the cycle after the read strobe.
//
// Added by the designer: the address-and-strobe port.

`default_nettype none

module aic_ctrl (
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	input  wire aic_pkg::aic_bus_req_t bus_req,
	output logic      [7:0]           bus_rdata,
	input  wire logic                 comp_in,
	output aic_pkg::aic_afe_t         afe,
	output aic_pkg::aic_result_t      result
);
	import aic_pkg::*;

	logic [7:0]  setup_r;
	logic [4:0]  chan_r;
	logic        single_r;
	logic        cont_r;
	aic_state_t  state_r;
	aic_state_t  state_nxt;
	aic_kind_t   kind_r;
	logic [CNT_W-1:0] settle_r;
	logic [3:0]  bit_idx_r;
	logic [9:0]  code_r;
	logic        phase_r;
	logic [9:0]  tlo_r;
	logic [7:0]  rdata_r;
	aic_afe_t    afe_r;
	aic_result_t res_r;

	logic        run_lock;
	logic        wr_setup;
	logic        wr_ctrl;
	logic        start;
	logic        last_phase;
	logic        finish;
	aic_kind_t   kind_now;

	// Classifies the selected channel by the measurement it needs.
	function automatic aic_kind_t chan_kind(input logic [4:0] ch,
	                                        input logic [7:0] setup);
		aic_kind_t k;
		k = KIND_INTERNAL;
		if (ch <= CH_IN4) begin
			if ((ch == CH_IN3 && setup[BIT_TEMP3]) ||
			    (ch == CH_IN4 && setup[BIT_TEMP4])) begin
				k = KIND_TEMP;
			end else if (setup[ch[1:0]]) begin
				k = KIND_ABS;
			end else begin
				k = KIND_RATIO;
			end
		end
		return k;
	endfunction

	// True for codes in the reserved gap, which leave the multiplexer open.
	function automatic logic chan_reserved(input logic [4:0] ch);
		return (ch >= CH_RSV_FIRST) && (ch <= CH_RSV_LAST);
	endfunction

	// One-hot mask of the bit under trial.
	function automatic logic [CODE_W-1:0] trial_bit(input logic [3:0] idx);
		return CODE_W'(1) << idx;
	endfunction

	// A pending single request already counts as running, so a write in the
	// cycle before the sequencer leaves idle cannot slip past the lock.
	// Continuous request alone also holds it, so that software cannot move
	// the channel between back-to-back conversions.
	assign run_lock   = (state_r != ST_IDLE) || cont_r ||
	                    single_r;
	assign wr_setup   = bus_req.wr && (bus_req.addr == OFS_SETUP);
	assign wr_ctrl    = bus_req.wr && (bus_req.addr == OFS_CTRL);
	assign start      = (state_r == ST_IDLE) && (single_r || cont_r);
	assign kind_now   = chan_kind(chan_r, setup_r);
	assign last_phase = (kind_r != KIND_TEMP) || phase_r;
	assign finish     = (state_r == ST_DONE) && last_phase;

	// Input setup register.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			setup_r <= SETUP_RESET;
		end else if (wr_setup && !run_lock) begin
			setup_r <= bus_req.wdata;
		end
	end

	// Channel select field, frozen while running.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			chan_r <= CHAN_RESET;
		end else if (wr_ctrl && !run_lock) begin
			chan_r <= bus_req.wdata[4:0];
		end
	end

	// Continuous request; may be cleared at any time to stop after the
	// current conversion.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cont_r <= 1'b0;
		end else if (wr_ctrl) begin
			cont_r <= bus_req.wdata[BIT_CONT];
		end
	end

	// Single request; a write that sets it in the completion cycle wins.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			single_r <= 1'b0;
		end else if (wr_ctrl) begin
			single_r <= bus_req.wdata[BIT_SINGLE];
		end else if (finish && !cont_r) begin
			single_r <= 1'b0;
		end
	end

	// Sequencer state.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start) begin
					state_nxt = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (settle_r == '0) begin
					state_nxt = ST_TRY;
				end
			end
			ST_TRY: begin
				state_nxt = ST_CMP;
			end
			ST_CMP: begin
				if (bit_idx_r == 4'h0) begin
					state_nxt = ST_DONE;
				end else begin
					state_nxt = ST_TRY;
				end
			end
			ST_DONE: begin
				// A temperature run always takes its second current level.
				// Continuous mode dominates a pending single request.
				if (!last_phase || cont_r) begin
					state_nxt = ST_SETTLE;
				end else if (single_r) begin
					state_nxt = ST_IDLE;
				end else begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Measurement type is fixed when a conversion starts from idle.
	// Holding it keeps one run on one sequence even if the decode of the
	// selected input would change under it.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			kind_r <= KIND_RATIO;
		end else if (start) begin
			kind_r <= kind_now;
		end
	end

	// Temperature phase: low current first, then the tenfold level.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			phase_r <= 1'b0;
		end else if (start) begin
			phase_r <= 1'b0;
		end else if (state_r == ST_DONE) begin
			phase_r <= !last_phase;
		end
	end

	// Settling counter, reloaded whenever the sequencer enters settling.
	// The second temperature pass settles too, since the diode voltage needs
	// time to follow the current step.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			settle_r <= '0;
		end else if (state_nxt == ST_SETTLE && state_r != ST_SETTLE) begin
			settle_r <= CNT_W'(SETTLE_CYC - 1);
		end else if (state_r == ST_SETTLE && settle_r != '0) begin
			settle_r <= settle_r - CNT_W'(1);
		end
	end

	// Successive approximation: one trial cycle and one decision cycle per
	// bit, so the comparator has a full cycle to settle on each trial.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			code_r    <= '0;
			bit_idx_r <= 4'h0;
		end else begin
			case (state_r)
				ST_SETTLE: begin
					code_r    <= '0;
					bit_idx_r <= 4'(CODE_W - 1);
				end
				ST_TRY: begin
					code_r <= code_r | trial_bit(bit_idx_r);
				end
				ST_CMP: begin
					if (!comp_in) begin
						code_r[bit_idx_r] <= 1'b0;
					end
					if (bit_idx_r != 4'h0) begin
						bit_idx_r <= bit_idx_r - 4'h1;
					end
				end
				default: begin
					code_r    <= code_r;
					bit_idx_r <= bit_idx_r;
				end
			endcase
		end
	end

	// First temperature result, taken at the low current level.
	// Software pairs it with the final result to work out the temperature.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			tlo_r <= '0;
		end else if (state_r == ST_DONE && !last_phase) begin
			tlo_r <= code_r;
		end
	end

	// Final result with sign and a one-cycle valid pulse.
	// Code and valid land on the same edge, so a poller never sees a
	// half-updated result.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			res_r <= '0;
		end else begin
			res_r.valid <= finish;
			res_r.busy  <= (state_nxt != ST_IDLE);
			if (finish) begin
				res_r.code <= code_r;
				// Upper half of the supply span reads as positive.
				res_r.sign_pos <= (kind_r == KIND_RATIO) ?
				                  code_r[CODE_W-1] : 1'b1;
			end
		end
	end

	// Analog control outputs, all registered.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			afe_r <= '0;
		end else begin
			afe_r.mux_sel  <= chan_r;
			// Reserved codes leave the multiplexer open.
			afe_r.mux_en   <= !chan_reserved(chan_r);
			// Reference tracks the selection even while idle.
			afe_r.ref_from_supply <=
				(kind_now == KIND_RATIO);
			afe_r.pos_supply_switch_en <= setup_r[BIT_POS_SW];
			afe_r.neg_supply_switch_en <= setup_r[BIT_NEG_SW];
			// Sources run only while their own input is converted.
			afe_r.temp_source_en[0] <= (state_nxt != ST_IDLE) &&
			                           (kind_r == KIND_TEMP || start) &&
			                           (kind_now == KIND_TEMP) &&
			                           (chan_r == CH_IN3);
			afe_r.temp_source_en[1] <= (state_nxt != ST_IDLE) &&
			                           (kind_r == KIND_TEMP || start) &&
			                           (kind_now == KIND_TEMP) &&
			                           (chan_r == CH_IN4);
			afe_r.current_high <= (state_r == ST_DONE) ? !last_phase :
			                      (phase_r && !start);
			afe_r.sample   <= (state_nxt == ST_SETTLE);
			// The trial bit goes out in the decision cycle itself, so the
			// comparator judges the code under trial, not the one before.
			if (state_r == ST_TRY) begin
				afe_r.dac_code <= code_r | trial_bit(bit_idx_r);
			end else begin
				afe_r.dac_code <= code_r;
			end
		end
	end

	// Register read port: data stands in the cycle after the strobe.
	// The result bytes are not latched against each other: read them while
	// the converter is idle, or the two halves may come from two runs.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rdata_r <= 8'h00;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				OFS_SETUP: begin
					rdata_r <= setup_r;
				end
				OFS_CTRL: begin
					rdata_r <= {1'b0, cont_r, single_r, chan_r};
				end
				OFS_RES_LO: begin
					rdata_r <= res_r.code[7:0];
				end
				OFS_RES_HI: begin
					rdata_r <= {res_r.busy, res_r.sign_pos,
					            4'h0, res_r.code[9:8]};
				end
				OFS_TLO_LO: begin
					rdata_r <= tlo_r[7:0];
				end
				OFS_TLO_HI: begin
					rdata_r <= {6'h00, tlo_r[9:8]};
				end
				default: begin
					rdata_r <= 8'h00;
				end
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign bus_rdata = rdata_r;
	assign afe       = afe_r;
	assign result    = res_r;

endmodule

`default_nettype wire

// [aic_ctrl_checker.sv]
// Purpose: Concurrent checks on the converter front-end control ports.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound to every aic_ctrl instance.
`default_nettype none

module aic_ctrl_checker (
	input wire logic                  clk_sys,
	input wire logic                  rstn,
	input wire aic_pkg::aic_bus_req_t bus_req,
	input wire logic [7:0]            bus_rdata,
	input wire logic                  comp_in,
	input wire aic_pkg::aic_afe_t     afe,
	input wire aic_pkg::aic_result_t  result
);
	timeunit 1ns;
	timeprecision 1ns;
	import aic_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	AST_CTRL_B7: assert property ($past(bus_req.rd) &&
		$past(bus_req.addr) == OFS_CTRL |-> bus_rdata[7] == 1'b0)
		else $error("control bit 7 read as one");
	// Two edges of grace: the outputs are registered copies of registers.
	AST_MUX_EN: assert property ($past(rstn, 2) |-> afe.mux_en ==
		!(afe.mux_sel inside {[CH_RSV_FIRST:CH_RSV_LAST]}))
		else $error("mux enable wrong for channel code");
	AST_SEL_HOLD: assert property (result.busy &&
		$past(result.busy) |-> $stable(afe.mux_sel))
		else $error("channel changed during conversion");
	AST_SW_HOLD: assert property (result.busy &&
		$past(result.busy) |-> $stable(afe.pos_supply_switch_en) &&
		$stable(afe.neg_supply_switch_en) && $stable(afe.temp_source_en))
		else $error("input setup changed during conversion");
	AST_VALID_END: assert property (result.valid |->
		$past(result.busy) ##1 !result.valid)
		else $error("result pulse not ending a conversion");
	AST_SETTLE: assert property ($rose(result.busy) |->
		afe.sample [*8])
		else $error("no settling phase at conversion start");
	AST_CURR: assert property (afe.current_high |->
		afe.temp_source_en != 2'h0)
		else $error("high current without temperature input");
	AST_REF: assert property (afe.ref_from_supply |->
		afe.mux_sel <= CH_IN4)
		else $error("supply reference on non-external channel");
	AST_SIGN: assert property (result.valid |-> result.sign_pos ==
		(afe.ref_from_supply ? result.code[9] : 1'b1))
		else $error("result sign wrong");

	cover property (result.valid);
	cover property (afe.current_high);
	cover property ($rose(result.busy) && afe.mux_sel == CH_IN3);
endmodule

bind aic_ctrl aic_ctrl_checker u_aic_ctrl_checker (
	.clk_sys   (clk_sys),
	.rstn      (rstn),
	.bus_req   (bus_req),
	.bus_rdata (bus_rdata),
	.comp_in   (comp_in),
	.afe       (afe),
	.result    (result)
);

`default_nettype wire

// [aic_pkg.sv]
// Purpose: Shared constants and types for the analog input front-end control.
// Assumes: One system clock at 25 MHz, synchronous active-low reset.
// Notes:   Register offsets are byte addresses on the plain register port.
// Functional notes
// - Mode bits 3:0 select absolute when set, ratiometric when clear.
// - Setup bit 7 connects positive sensor supply pin to internal 5.0V.
// - Setup bit 6 ties negative sensor supply pin to analog ground.
// - Bits 5:4 enable diode temperature on inputs three and four.
// - Temperature runs use two source current levels in a 1:10 ratio.
// - Setup register ignores writes while a conversion runs.
// - Control bits 4:0 select the input multiplexer channel.
// - Channel select writes are blocked while a conversion runs.
// - Reference follows the selected channel without software action.
// - A started conversion runs the sequence for the selected input type.
// - Control bit 5 requests single, bit 6 continuous conversion.
// - Conversions use a 10-bit successive approximation search.
// - Ratiometric mode takes the reference from the sensor supply pins.
// - Absolute mode uses the internal reference.
// - Ratiometric sign is positive in the upper half of the span.
// - Control bit 7 reads zero and ignores writes.
// - Single request bit clears itself when its conversion completes.
// - With both request bits set, continuous mode wins.
// - Codes 0 to 3 pick external inputs; 19 to 24 are reserved.

`default_nettype none

package aic_pkg;

	localparam int          ADDR_W         = 8;
	localparam int          DATA_W         = 8;
	localparam int          CODE_W         = 10;

	localparam logic [7:0]  OFS_SETUP      = 8'h10;
	localparam logic [7:0]  OFS_CTRL       = 8'h12;
	localparam logic [7:0]  OFS_RES_LO     = 8'h14;
	localparam logic [7:0]  OFS_RES_HI     = 8'h15;
	localparam logic [7:0]  OFS_TLO_LO     = 8'h16;
	localparam logic [7:0]  OFS_TLO_HI     = 8'h17;

	localparam logic [7:0]  SETUP_RESET    = 8'h00;
	localparam logic [4:0]  CHAN_RESET     = 5'h00;
	localparam int          BIT_POS_SW     = 7;
	localparam int          BIT_NEG_SW     = 6;
	localparam int          BIT_TEMP4      = 5;
	localparam int          BIT_TEMP3      = 4;
	localparam int          BIT_CONT       = 6;
	localparam int          BIT_SINGLE     = 5;

	localparam logic [4:0]  CH_IN1         = 5'h00;
	localparam logic [4:0]  CH_IN3         = 5'h02;
	localparam logic [4:0]  CH_IN4         = 5'h03;
	localparam logic [4:0]  CH_RSV_FIRST   = 5'h13;
	localparam logic [4:0]  CH_RSV_LAST    = 5'h18;

	// Settling time before the search starts, and after a current step.
	localparam int          CLK_NS         = 40;
	localparam int          SETTLE_NS      = 2000;
	localparam int          SETTLE_CYC     = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int          CNT_W          = 8;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_SETTLE = 3'h1,
		ST_TRY    = 3'h2,
		ST_CMP    = 3'h3,
		ST_DONE   = 3'h4
	} aic_state_t;

	typedef enum logic [1:0] {
		KIND_RATIO    = 2'h0,
		KIND_ABS      = 2'h1,
		KIND_TEMP     = 2'h2,
		KIND_INTERNAL = 2'h3
	} aic_kind_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} aic_bus_req_t;

	typedef struct packed {
		logic [4:0] mux_sel;
		logic       mux_en;
		logic       ref_from_supply;
		logic       pos_supply_switch_en;
		logic       neg_supply_switch_en;
		logic [1:0] temp_source_en;
		logic       current_high;
		logic       sample;
		logic [9:0] dac_code;
	} aic_afe_t;

	typedef struct packed {
		logic [9:0] code;
		logic       sign_pos;
		logic       valid;
		logic       busy;
	} aic_result_t;

endpackage

`default_nettype wire

// [aic_sensor_model.sv]
// Purpose: Sensor and comparator seen from the converter front end.
// Assumes: An ideal comparator with no offset.
// Notes:   Levels are set by the bench per conversion.
`default_nettype none

module aic_sensor_model (
	input  wire aic_pkg::aic_afe_t afe,
	input  wire logic [9:0]        level_lo,
	input  wire logic [9:0]        level_hi,
	output logic                   comp_in
);
	timeunit 1ns;
	timeprecision 1ns;
	import aic_pkg::*;
	logic [9:0] level;
	// A diode reads differently at tenfold current, so each phase has a level.
	assign level = afe.current_high ? level_hi : level_lo;
	assign comp_in = (level >= afe.dac_code);
endmodule

`default_nettype wire

// [tb_top.sv]
// Purpose: Self-checking bench for the converter front-end control.
// Assumes: Random values from a fixed-seed shift register.
// Notes:   Expected codes equal the sensor levels of an ideal comparator.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import aic_pkg::*;
	logic         clk_sys = 1'b0;
	logic         rstn = 1'b0;
	aic_bus_req_t req = '0;
	logic [7:0]   rdata;
	logic         comp;
	aic_afe_t     afe;
	aic_result_t  res;
	logic [9:0]   lvl_lo = 10'h000;
	logic [9:0]   lvl_hi = 10'h000;
	logic [31:0]  seed = 32'h2E8589EE;
	int           fail_count = 0;
	int           compares = 0;

	always #20 clk_sys = ~clk_sys;

	aic_ctrl u_aic_ctrl (.clk_sys(clk_sys), .rstn(rstn), .bus_req(req),
		.bus_rdata(rdata), .comp_in(comp), .afe(afe), .result(res));
	aic_sensor_model u_aic_sensor_model (.afe(afe), .level_lo(lvl_lo),
		.level_hi(lvl_hi), .comp_in(comp));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction

	function automatic logic exp_ref(input logic [1:0] ch,
		input logic [7:0] s);
		if (ch[1] && s[4 + ch[0]])
			return 1'b0;
		return !s[ch];
	endfunction

	task automatic summarize();
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string w, input logic [15:0] e,
		input logic [15:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input string w);
		@(posedge clk_sys);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		req.rd <= 1'b0;
		#1 chk(w, e, rdata);
	endtask

	task automatic wait_valid();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while (res.valid !== 1'b1 && n < 400);
		chk("valid", 1'b1, res.valid);
	endtask

	task automatic conv(input logic [7:0] s, input logic [1:0] ch,
		input logic [9:0] lo, input logic [9:0] hi);
		logic       tmp;
		logic       rat;
		logic       sgn;
		logic [1:0] ten;
		logic [9:0] fin;
		tmp = ch[1] && s[4 + ch[0]];
		rat = exp_ref(ch, s);
		fin = tmp ? hi : lo;
		sgn = rat ? fin[9] : 1'b1;
		// Only the source of the diode input under conversion runs.
		ten = tmp ? (ch[0] ? 2'h2 : 2'h1) : 2'h0;
		lvl_lo <= lo;
		lvl_hi <= hi;
		wr(OFS_SETUP, s);
		wr(OFS_CTRL, 8'h20 | {6'h00, ch});
		repeat (4) @(posedge clk_sys);
		#1 chk("busy", 1'b1, res.busy);
		wr(OFS_SETUP, ~s);
		wr(OFS_CTRL, 8'h20 | {6'h00, ~ch});
		rd(OFS_SETUP, s, "setup_lock");
		rd(OFS_CTRL, 8'h20 | {6'h00, ch}, "chan_lock");
		chk("mux_sel", {3'h0, ch}, afe.mux_sel);
		chk("ref", rat, afe.ref_from_supply);
		chk("pos_sw", s[7], afe.pos_supply_switch_en);
		chk("neg_sw", s[6], afe.neg_supply_switch_en);
		chk("temp_en", ten, afe.temp_source_en);
		wait_valid();
		chk("code", fin, res.code);
		chk("sign", sgn, res.sign_pos);
		rd(OFS_RES_LO, fin[7:0], "res_lo");
		rd(OFS_RES_HI, {1'b0, sgn, 4'h0, fin[9:8]}, "res_hi");
		rd(OFS_CTRL, {6'h00, ch}, "single_clr");
		if (tmp) begin
			rd(OFS_TLO_LO, lo[7:0], "temp_low");
			rd(OFS_TLO_HI, {6'h00, lo[9:8]}, "temp_low_hi");
		end
	endtask

	initial begin
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(OFS_SETUP, SETUP_RESET, "setup_rst");
		rd(OFS_CTRL, 8'h00, "ctrl_rst");
		rd(8'h40, 8'h00, "unmapped");
		chk("mux_en_rst", 1'b1, afe.mux_en);
		chk("ref_rst", 1'b1, afe.ref_from_supply);
		wr(OFS_CTRL, 8'h80 | {3'h0, CH_RSV_FIRST});
		rd(OFS_CTRL, {3'h0, CH_RSV_FIRST}, "ctrl_b7");
		chk("mux_en_rsv", 1'b0, afe.mux_en);
		conv(8'h00, 2'h0, 10'h200, 10'h000);
		conv(8'h00, 2'h1, 10'h1FF, 10'h000);
		conv(8'h14, 2'h2, 10'h0AB, 10'h3FF);
		conv(8'hE8, 2'h3, 10'h000, 10'h200);
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			conv(seed[7:0], seed[9:8], seed[19:10], seed[29:20]);
		end
		// Both requests on a reserved code: internal reference, free running.
		wr(OFS_CTRL, 8'h60 | {3'h0, CH_RSV_FIRST});
		wait_valid();
		chk("code_int", lvl_lo, res.code);
		chk("sign_int", 1'b1, res.sign_pos);
		chk("ref_int", 1'b0, afe.ref_from_supply);
		chk("mux_en_run", 1'b0, afe.mux_en);
		wait_valid();
		rd(OFS_CTRL, 8'h60 | {3'h0, CH_RSV_FIRST}, "both_req");
		wr(OFS_CTRL, {3'h0, CH_RSV_FIRST});
		wait_valid();
		repeat (4) @(posedge clk_sys);
		#1 chk("stopped", 1'b0, res.busy);
		summarize();
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		summarize();
	end
endmodule

`default_nettype wire
